// [mscg_top.sv]
// motion system clock generator: phase, servo and local clock dividers
`timescale 1ns/1ps
// Contract
// - one chip sources phase and servo onto backplane; all others take them in
// - direction 0 drives both clocks out, direction 3 receives both
// - host interrupts on phase and servo; receivers time their functions by them
// - phase clock generated at the programmed frequency in hertz, default 9035
// - receiver locks its internal phase clock to the backplane phase clock
// - receiver divides received phase by 2, 3, 4 for settings 1, 2, 3
// - source multiplies its output phase frequency by 2, 3, 4 for 1, 2, 3
// - servo clock is phase clock divided by servo setting plus one
// - servo divide setting resets to 3, one servo per four phases
// - with external servo clock the servo divide setting has no effect
// - six local clocks with own dividers, never shared between chips
// - each local divider divides its source by two to the power n
// - five local clocks divide from the main source clock
// - those five dividers reset to setting 5, divide by 32
// - filter clock divides from sampling clock, resets to setting 4
// - protected write needs unlock key, key cleared after each protected write
module mscg_top (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic cfg_wr_i,
   input wire mscg_pkg::mscg_cfg_t cfg_i,
   input wire logic key_wr_i,
   input wire logic [31:0] key_i,
   input wire mscg_pkg::mscg_sys_t sys_i,
   output logic [1:0] sys_o,
   output logic [1:0] sys_oe_n_o,
   output logic phase_tick_o,
   output logic servo_tick_o,
   output logic [5:0] loc_en_o,
   output mscg_pkg::mscg_cfg_t cfg_o,
   output logic unlocked_o,
   output logic locked_o
);
   import mscg_pkg::*;

   // ----------------------------------------
   // protected settings
   // ----------------------------------------
   mscg_cfg_t cfg_q, cfg_d;
   logic [31:0] key_q, key_d;
   logic unlocked_q, unlocked_d;

   always_comb begin
      cfg_d = cfg_q;
      key_d = key_q;
      // a protected write consumes the key; a key write in that cycle is lost
      if (cfg_wr_i && key_q == WP_UNLOCK) begin
         cfg_d = cfg_i;
         key_d = '0;
      end else if (key_wr_i) begin
         key_d = key_i;
      end
      // registered decode keeps the status output glitch free
      unlocked_d = (key_d == WP_UNLOCK);
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_q <= CFG_RST;
         key_q <= '0;
         unlocked_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         key_q <= key_d;
         unlocked_q <= unlocked_d;
      end
   end

   logic phase_in;
   logic servo_in;
   assign phase_in = cfg_q.dir[0];
   assign servo_in = cfg_q.dir[1];

   // ----------------------------------------
   // backplane input synchronisers
   // ----------------------------------------
   mscg_sys_t s1_q, s2_q, s3_q;
   mscg_sys_t rx_edge;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= sys_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign rx_edge = s2_q & ~s3_q;

   // ----------------------------------------
   // received phase divider
   // ----------------------------------------
   logic [1:0] rx_cnt_q, rx_cnt_d, rx_div_q, rx_div_d;
   logic rx_tick;

   always_comb begin
      rx_cnt_d = rx_cnt_q;
      rx_div_d = rx_div_q;
      rx_tick = 1'b0;
      if (rx_edge.phase) begin
         if (rx_cnt_q >= rx_div_q) begin
            rx_cnt_d = 2'h0;
            rx_tick = 1'b1;
            rx_div_d = cfg_q.rx_div;
         end else begin
            rx_cnt_d = rx_cnt_q + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_cnt_q <= '0;
         rx_div_q <= '0;
      end else begin
         rx_cnt_q <= rx_cnt_d;
         rx_div_q <= rx_div_d;
      end
   end

   // ----------------------------------------
   // phase oscillator and digital pll
   // ----------------------------------------
   logic [ACC_W-1:0] acc_q, acc_d, inc, sum;
   logic [1:0] mult_q, mult_d;
   logic signed [TRIM_W-1:0] trim_q, trim_d;
   logic [1:0] wraps_q, wraps_d;
   logic lock_q, lock_d;
   logic nco_wrap;
   logic [2:0] mult_fac;

   always_comb begin
      acc_d = acc_q;
      mult_d = mult_q;
      trim_d = trim_q;
      wraps_d = wraps_q;
      lock_d = lock_q;
      nco_wrap = 1'b0;
      // multiply only applies on the driving end
      mult_fac = phase_in ? 3'h1 : {1'b0, mult_q} + 3'h1;
      inc = ACC_W'(cfg_q.freq) * ACC_W'(mult_fac) + ACC_W'(trim_q);
      sum = acc_q + inc;
      if (sum >= ACC_W'(CLK_HZ)) begin
         acc_d = sum - ACC_W'(CLK_HZ);
         nco_wrap = 1'b1;
         mult_d = cfg_q.tx_mult;
         if (wraps_q != 2'h3) begin
            wraps_d = wraps_q + 2'h1;
         end
      end else begin
         acc_d = sum;
      end
      // coarse pll: realign at each divided received edge (rx_tick), trim rate by wrap count
      if (phase_in && rx_tick) begin
         acc_d = '0;
         wraps_d = 2'h0;
         lock_d = (wraps_q == 2'h1);
         if (wraps_q == 2'h0 && trim_q != 16'sh7FFF) begin
            trim_d = trim_q + 16'sh0001;
         end else if (wraps_q > 2'h1 && trim_q != -16'sh7FFF) begin
            trim_d = trim_q - 16'sh0001;
         end
      end
      if (!phase_in) begin
         trim_d = '0;
         lock_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_q <= '0;
         mult_q <= '0;
         trim_q <= '0;
         wraps_q <= '0;
         lock_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         mult_q <= mult_d;
         trim_q <= trim_d;
         wraps_q <= wraps_d;
         lock_q <= lock_d;
      end
   end

   // ----------------------------------------
   // phase and servo ticks, backplane drive
   // ----------------------------------------
   logic [3:0] svc_q, svc_d, sdiv_q, sdiv_d;
   logic ph_q, ph_d, sv_q, sv_d;
   logic [1:0] oe_n_q, oe_n_d;

   always_comb begin
      svc_d = svc_q;
      sdiv_d = sdiv_q;
      ph_d = phase_in ? rx_tick : nco_wrap;
      sv_d = 1'b0;
      oe_n_d = {servo_in, phase_in};
      if (servo_in) begin
         sv_d = rx_edge.servo;
      end else if (ph_d) begin
         if (svc_q >= sdiv_q) begin
            svc_d = 4'h0;
            sv_d = 1'b1;
            sdiv_d = cfg_q.servo_div;
         end else begin
            svc_d = svc_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         svc_q <= '0;
         sdiv_q <= SERVO_DIV_RST;
         ph_q <= 1'b0;
         sv_q <= 1'b0;
         oe_n_q <= '0;
      end else begin
         svc_q <= svc_d;
         sdiv_q <= sdiv_d;
         ph_q <= ph_d;
         sv_q <= sv_d;
         oe_n_q <= oe_n_d;
      end
   end

   // ----------------------------------------
   // local hardware clock dividers
   // ----------------------------------------
   logic [LOC_N-1:0] en_q;

   for (genvar g = 0; g < LOC_N; g++) begin : g_loc
      logic [LOC_CNT_W-1:0] cnt_q, cnt_d, lim;
      logic [3:0] n_q, n_d;
      logic en_d, src;
      // filter runs off the sampling enable, so it lags it by one cycle
      assign src = (g == LOC_FILT) ? en_q[LOC_SAMPLE] : 1'b1;

      always_comb begin
         cnt_d = cnt_q;
         n_d = n_q;
         en_d = 1'b0;
         lim = LOC_CNT_W'((16'h0001 << n_q) - 16'h0001);
         if (src) begin
            if (cnt_q >= lim) begin
               cnt_d = '0;
               en_d = 1'b1;
               n_d = cfg_q.loc_div[g];
            end else begin
               cnt_d = cnt_q + LOC_CNT_W'(1);
            end
         end
      end

      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            cnt_q <= '0;
            n_q <= CFG_RST.loc_div[g];
            en_q[g] <= 1'b0;
         end else begin
            cnt_q <= cnt_d;
            n_q <= n_d;
            en_q[g] <= en_d;
         end
      end

      a_loc_wrap: assert property (@(posedge clk_i) disable iff (!nrst_i)
         en_q[g] |-> cnt_q == '0) else $error("local enable without counter wrap");
   end

   assign sys_o = {sv_q, ph_q};
   assign sys_oe_n_o = oe_n_q;
   assign phase_tick_o = ph_q;
   assign servo_tick_o = sv_q;
   assign loc_en_o = en_q;
   assign cfg_o = cfg_q;
   assign unlocked_o = unlocked_q;
   assign locked_o = lock_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   a_key_cleared: assert property (cfg_wr_i && key_q == WP_UNLOCK |=> key_q == '0)
      else $error("key not cleared after protected write");
   a_locked_cfg: assert property (cfg_wr_i && key_q != WP_UNLOCK |=> $stable(cfg_q))
      else $error("protected settings changed without key");
   a_src_drive: assert property ((cfg_q.dir == DIR_SOURCE)[*2] |-> oe_n_q == 2'h0)
      else $error("source not driving backplane");
   a_rx_release: assert property ((cfg_q.dir == DIR_RECEIVE)[*2] |-> oe_n_q == 2'h3)
      else $error("receiver driving backplane");
   a_servo_on_phase: assert property (sv_q && !$past(servo_in) |-> ph_q)
      else $error("servo pulse not on phase pulse");
   a_servo_count: assert property (sv_q && !$past(servo_in) |-> svc_q == 4'h0)
      else $error("servo divider did not restart");
   a_servo_ext: assert property (servo_in && $past(servo_in) && sv_q |-> $past(rx_edge.servo))
      else $error("servo pulse not from backplane");
   a_nco_range: assert property (acc_q < ACC_W'(CLK_HZ))
      else $error("phase accumulator out of range");

endmodule

// [mscg_pkg.sv]
// package of constants and types for the motion system clock generator
package mscg_pkg;

   // ----------------------------------------
   // clocking
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned SRC_HZ = 100_000_000;
   localparam int ACC_W = 36;
   localparam int TRIM_W = 16;
   localparam int LOC_N = 6;
   localparam int LOC_CNT_W = 15;
   localparam int LOC_SAMPLE = 4;
   localparam int LOC_FILT = 5;

   // ----------------------------------------
   // settings and reset values
   // ----------------------------------------
   localparam logic [1:0] DIR_SOURCE = 2'h0;
   localparam logic [1:0] DIR_RECEIVE = 2'h3;
   localparam logic [31:0] WP_UNLOCK = 32'hAAAAAAAA;
   localparam logic [31:0] PHASE_FREQ_RST = 32'h0000234B;
   localparam logic [3:0] SERVO_DIV_RST = 4'h3;
   localparam logic [3:0] SRC_DIV_RST = 4'h5;
   localparam logic [3:0] FILT_DIV_RST = 4'h4;

   typedef struct packed {
      logic [1:0] dir;
      logic [31:0] freq;
      logic [1:0] rx_div;
      logic [1:0] tx_mult;
      logic [3:0] servo_div;
      logic [5:0][3:0] loc_div;
   } mscg_cfg_t;

   typedef struct packed {
      logic servo;
      logic phase;
   } mscg_sys_t;

   localparam mscg_cfg_t CFG_RST = '{
      dir: DIR_SOURCE,
      freq: PHASE_FREQ_RST,
      rx_div: 2'h0,
      tx_mult: 2'h0,
      servo_div: SERVO_DIV_RST,
      loc_div: {FILT_DIV_RST, SRC_DIV_RST, SRC_DIV_RST, SRC_DIV_RST, SRC_DIV_RST, SRC_DIV_RST}
   };

endpackage

// [mscg_peer.sv]
// backplane peer model: another chip sourcing the phase and servo clocks
`timescale 1ns/1ps
module mscg_peer #(
   parameter int PER = 200
) (
   input wire logic clk_i,
   input wire logic en_i,
   output mscg_pkg::mscg_sys_t sys_o
);
   import mscg_pkg::*;
   // ---------------------------------------
   // peer source clocks
   // ---------------------------------------
   int cnt;
   logic [1:0] nph;
   initial begin
      sys_o = '0;
      cnt = 0;
      nph = 2'h0;
   end
   // silent while the block sources, so the backplane never has two drivers
   always @(negedge clk_i) begin
      if (!en_i) begin
         sys_o <= '0;
         cnt <= 0;
      end else if (cnt == PER - 1) begin
         cnt <= 0;
         nph <= nph + 2'h1;
         sys_o.phase <= 1'b1;
         sys_o.servo <= (nph == 2'h3);
      end else begin
         cnt <= cnt + 1;
         sys_o <= '0;
      end
   end
endmodule

// [tb_mscg.sv]
// self-checking testbench for the motion system clock generator
`timescale 1ns/1ps
module testbench;
   import mscg_pkg::*;
   // ---------------------------------------
   // signals and tasks
   // ---------------------------------------
   typedef struct packed {mscg_cfg_t cfg; logic [3:0] sel; logic [15:0] per;} mscg_row_t;
   logic clk_i, nrst_i, cfg_wr_i, key_wr_i, phase_tick_o, servo_tick_o, unlocked_o, locked_o;
   logic [31:0] key_i;
   mscg_cfg_t cfg_i, cfg_o, c;
   mscg_sys_t sys_i;
   logic [1:0] sys_o, sys_oe_n_o;
   logic [5:0] loc_en_o;
   wire logic [7:0] obs = {servo_tick_o, phase_tick_o, loc_en_o};
   mscg_row_t rows [11];
   int err_total, compares, n;
   mscg_top i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .cfg_wr_i(cfg_wr_i), .cfg_i(cfg_i), .key_wr_i(key_wr_i),
      .key_i(key_i), .sys_i(sys_i), .sys_o(sys_o), .sys_oe_n_o(sys_oe_n_o), .phase_tick_o(phase_tick_o),
      .servo_tick_o(servo_tick_o), .loc_en_o(loc_en_o), .cfg_o(cfg_o), .unlocked_o(unlocked_o),
      .locked_o(locked_o));
   mscg_peer #(.PER(200)) i_peer (.clk_i(clk_i), .en_i(cfg_o.dir == DIR_RECEIVE), .sys_o(sys_i));
   task automatic results();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic bad(input string m);
      err_total++;
      $display("BAD %0t %s", $time, m);
   endtask
   task automatic chk_i(input int got, input int exp);
      compares++;
      if (got != exp) bad("period");
   endtask
   task automatic chk_b(input logic [1:0] got, input logic [1:0] exp, input string m);
      compares++;
      if (got !== exp) bad(m);
   endtask
   task automatic chk_c(input mscg_cfg_t got, input mscg_cfg_t exp);
      compares++;
      if (got !== exp) bad("settings");
   endtask
   task automatic wr(input mscg_cfg_t v);
      key_wr_i = 1'b1;
      key_i = WP_UNLOCK;
      @(negedge clk_i);
      key_wr_i = 1'b0;
      cfg_wr_i = 1'b1;
      cfg_i = v;
      chk_b(unlocked_o, 2'h1, "key");
      @(negedge clk_i);
      cfg_wr_i = 1'b0;
      @(negedge clk_i);
      chk_c(cfg_o, v);
      chk_b(unlocked_o, 2'h0, "key clear");
   endtask
   // third interval: the first is partial and a new setting lands only at a wrap
   task automatic per(input int b, output int p);
      for (int k = 0; k < 3; k++) begin
         p = 0;
         do begin
            @(negedge clk_i);
            p++;
            if (p > 5000) begin
               bad("no pulse");
               results();
            end
         end while (obs[b] !== 1'b1);
      end
   endtask
   task automatic put(input int i, input int s, input int p);
      rows[i].cfg = c;
      rows[i].sel = 4'(s);
      rows[i].per = 16'(p);
   endtask
   // ---------------------------------------
   // stimulus
   // ---------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial begin
      nrst_i = 1'b0;
      cfg_wr_i = 1'b0;
      key_wr_i = 1'b0;
      key_i = 32'h00000000;
      cfg_i = CFG_RST;
      err_total = 0;
      compares = 0;
      c = CFG_RST;
      c.freq = 32'h00061A80;
      put(0, 6, 100);
      put(1, 7, 400);
      c.tx_mult = 2'h1;
      put(2, 6, 50);
      c.tx_mult = 2'h3;
      c.servo_div = 4'hF;
      put(3, 7, 400);
      c.loc_div[0] = 4'h0;
      put(4, 0, 1);
      c.loc_div[1] = 4'hA;
      put(5, 1, 1024);
      c.loc_div[2] = 4'h3;
      put(6, 2, 8);
      c.loc_div[4] = 4'h2;
      c.loc_div[5] = 4'h2;
      put(7, 5, 16);
      c.dir = DIR_RECEIVE;
      c.rx_div = 2'h3;
      c.freq = 32'h00033450;
      put(8, 6, 800);
      c.rx_div = 2'h1;
      put(9, 6, 400);
      c.rx_div = 2'h0;
      c.servo_div = 4'h0;
      put(10, 7, 800);
      repeat (4) @(negedge clk_i);
      chk_c(cfg_o, CFG_RST);
      chk_b(sys_oe_n_o, 2'h0, "source role");
      nrst_i = 1'b1;
      $display("test reset done");
      for (int i = 0; i < 11; i++) begin
         wr(rows[i].cfg);
         per(rows[i].sel, n);
         chk_i(n, rows[i].per);
         $display("test row %0d done", i);
      end
      per(6, n);
      chk_i(n, 200);
      chk_b(locked_o, 2'h1, "lock");
      chk_b(sys_oe_n_o, 2'h3, "receive role");
      $display("test receive done");
      c = CFG_RST;
      c.freq = 32'h00061A80;
      wr(c);
      per(7, n);
      chk_b({servo_tick_o, phase_tick_o}, 2'h3, "servo align");
      chk_b(sys_o, 2'h3, "backplane drive");
      $display("test align done");
      cfg_i = CFG_RST;
      cfg_wr_i = 1'b1;
      @(negedge clk_i);
      cfg_wr_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk_c(cfg_o, c);
      $display("test refused done");
      nrst_i = 1'b0;
      @(negedge clk_i);
      chk_c(cfg_o, CFG_RST);
      chk_b(sys_oe_n_o, 2'h0, "reset role");
      nrst_i = 1'b1;
      $display("test second reset done");
      results();
   end
endmodule
